/* core/rmb_buck_regs.v */
// Top of the retained scratch and buck converter register bank
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defs.vh"
module rmb_buck_regs (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire       coin_cell_power_on_reset_n,
  input  wire       loadDefaults,
  input  wire [7:0] otpBuckOneVoltage,
  input  wire [7:0] otpBuckOneConfig,
  input  wire [7:0] otpBuckTwoConfig,
  input  wire [7:0] otpBuckThreeConfig,
  input  wire [7:0] seqBuckOneMode,
  input  wire [7:0] seqBuckTwoVoltage,
  input  wire [7:0] seqBuckTwoMode,
  input  wire [7:0] seqBuckThreeVoltage,
  input  wire [7:0] seqBuckThreeMode,
  input  wire [7:0] seqAlwaysOnControl,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  output reg  [4:0] buckOneVoltageSel,
  output reg  [4:0] buckTwoVoltageSel,
  output reg  [4:0] buckThreeVoltageSel,
  output reg  [3:0] buckOneModeSel,
  output reg  [3:0] buckTwoModeSel,
  output reg  [3:0] buckThreeModeSel,
  output reg  [1:0] buckOnePhaseSel,
  output reg  [1:0] buckTwoPhaseSel,
  output reg  [1:0] buckThreePhaseSel,
  output reg  [1:0] buckOneFreqSel,
  output reg  [1:0] buckTwoFreqSel,
  output reg  [1:0] buckThreeFreqSel,
  output reg        buckOneCurrentLimitSel,
  output reg        buckTwoCurrentLimitSel,
  output reg        buckThreeCurrentLimitSel,
  output reg  [2:0] alwaysOnSupplyVoltageSel
);
  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  localparam NREG = 10;

  // Slot of each bank register in the packed vectors below
  localparam B1_VOLT = 0;
  localparam B1_MODE = 1;
  localparam B1_CONF = 2;
  localparam B2_VOLT = 3;
  localparam B2_MODE = 4;
  localparam B2_CONF = 5;
  localparam B3_VOLT = 6;
  localparam B3_MODE = 7;
  localparam B3_CONF = 8;
  localparam AON_CTL = 9;

  wire [7:0]      scratchC;
  wire [7:0]      scratchD;
  wire [8*NREG-1:0] regVals;
  wire [8*NREG-1:0] regDefaults;
  wire [8*NREG-1:0] regOffsets;
  wire [8*NREG-1:0] regMasks;
  wire [NREG-1:0]   regHit;

  // Slots are filled by index, so a reordered list cannot skew the fields
  assign regOffsets[8*B1_VOLT +: 8] = `RMB_OFS_B1_VOLT;
  assign regOffsets[8*B1_MODE +: 8] = `RMB_OFS_B1_MODE;
  assign regOffsets[8*B1_CONF +: 8] = `RMB_OFS_B1_CONF;
  assign regOffsets[8*B2_VOLT +: 8] = `RMB_OFS_B2_VOLT;
  assign regOffsets[8*B2_MODE +: 8] = `RMB_OFS_B2_MODE;
  assign regOffsets[8*B2_CONF +: 8] = `RMB_OFS_B2_CONF;
  assign regOffsets[8*B3_VOLT +: 8] = `RMB_OFS_B3_VOLT;
  assign regOffsets[8*B3_MODE +: 8] = `RMB_OFS_B3_MODE;
  assign regOffsets[8*B3_CONF +: 8] = `RMB_OFS_B3_CONF;
  assign regOffsets[8*AON_CTL +: 8] = `RMB_OFS_AON_CTL;

  assign regMasks[8*B1_VOLT +: 8] = `RMB_MASK_VOLT;
  assign regMasks[8*B1_MODE +: 8] = `RMB_MASK_MODE;
  assign regMasks[8*B1_CONF +: 8] = `RMB_MASK_CONF;
  assign regMasks[8*B2_VOLT +: 8] = `RMB_MASK_VOLT;
  assign regMasks[8*B2_MODE +: 8] = `RMB_MASK_MODE;
  assign regMasks[8*B2_CONF +: 8] = `RMB_MASK_CONF;
  assign regMasks[8*B3_VOLT +: 8] = `RMB_MASK_VOLT;
  assign regMasks[8*B3_MODE +: 8] = `RMB_MASK_MODE;
  assign regMasks[8*B3_CONF +: 8] = `RMB_MASK_CONF;
  assign regMasks[8*AON_CTL +: 8] = `RMB_MASK_AON;

  assign regDefaults[8*B1_VOLT +: 8] = otpBuckOneVoltage;
  assign regDefaults[8*B1_MODE +: 8] = seqBuckOneMode;
  assign regDefaults[8*B1_CONF +: 8] = otpBuckOneConfig;
  assign regDefaults[8*B2_VOLT +: 8] = seqBuckTwoVoltage;
  assign regDefaults[8*B2_MODE +: 8] = seqBuckTwoMode;
  assign regDefaults[8*B2_CONF +: 8] = otpBuckTwoConfig;
  assign regDefaults[8*B3_VOLT +: 8] = seqBuckThreeVoltage;
  assign regDefaults[8*B3_MODE +: 8] = seqBuckThreeMode;
  assign regDefaults[8*B3_CONF +: 8] = otpBuckThreeConfig;
  assign regDefaults[8*AON_CTL +: 8] = seqAlwaysOnControl;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire            hitScratchC;
  wire            hitScratchD;
  wire            wrScratchC;
  wire            wrScratchD;
  wire [NREG-1:0] regWrEn;

  assign hitScratchC = (regAddr == `RMB_OFS_SCRATCH_C);
  assign hitScratchD = (regAddr == `RMB_OFS_SCRATCH_D);
  // Writes are taken at any time; there is no lock to honour
  assign wrScratchC  = regWrite && hitScratchC;
  assign wrScratchD  = regWrite && hitScratchD;

  // ---------------------------------------------------------------
  // Scratch bytes and bank slots
  // ---------------------------------------------------------------

  rmb_scratch_cell u_scratchC (
    .core_clk                   (core_clk),
    .coin_cell_power_on_reset_n (coin_cell_power_on_reset_n),
    .wrEn                       (wrScratchC),
    .wrData                     (regWrData),
    .value                      (scratchC)
  );

  rmb_scratch_cell u_scratchD (
    .core_clk                   (core_clk),
    .coin_cell_power_on_reset_n (coin_cell_power_on_reset_n),
    .wrEn                       (wrScratchD),
    .wrData                     (regWrData),
    .value                      (scratchD)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      assign regHit[gi] = (regAddr == regOffsets[8*gi +: 8]);
      assign regWrEn[gi] = regWrite && regHit[gi];
      rmb_masked_reg #(
        .MASK (`RMB_MASK_SCRATCH)
      ) u_reg (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .loadDefault  (loadDefaults),
        .defaultValue (regDefaults[8*gi +: 8] & regMasks[8*gi +: 8]),
        .wrEn         (regWrEn[gi]),
        .wrData       (regWrData & regMasks[8*gi +: 8]),
        .value        (regVals[8*gi +: 8])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  reg [7:0] nxt_rdData;
  integer   k;

  always @* begin
    nxt_rdData = `RMB_RD_UNMAPPED;
    if (hitScratchC) begin
      nxt_rdData = scratchC;
    end else if (hitScratchD) begin
      nxt_rdData = scratchD;
    end
    for (k = 0; k < NREG; k = k + 1) begin
      if (regHit[k]) begin
        nxt_rdData = regVals[8*k +: 8];
      end
    end
  end

  // Read data is held until the next read strobe, which lets a serial
  // front end shift it out at its own pace
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= nxt_rdData;
    end
  end

  // ---------------------------------------------------------------
  // Field extraction from the stored bytes
  // ---------------------------------------------------------------
  wire [4:0] fldB1Volt;
  wire [3:0] fldB1Mode;
  wire [1:0] fldB1Phase;
  wire [1:0] fldB1Freq;
  wire       fldB1Ilim;

  wire [4:0] fldB2Volt;
  wire [3:0] fldB2Mode;
  wire [1:0] fldB2Phase;
  wire [1:0] fldB2Freq;
  wire       fldB2Ilim;

  wire [4:0] fldB3Volt;
  wire [3:0] fldB3Mode;
  wire [1:0] fldB3Phase;
  wire [1:0] fldB3Freq;
  wire       fldB3Ilim;

  wire [2:0] fldAonVolt;

  assign fldB1Volt  = regVals[8*B1_VOLT +: 5];
  assign fldB1Mode  = regVals[8*B1_MODE +: 4];
  assign fldB1Phase = regVals[8*B1_CONF + `RMB_PHASE_LSB +: 2];
  assign fldB1Freq  = regVals[8*B1_CONF + `RMB_FREQ_LSB +: 2];
  assign fldB1Ilim  = regVals[8*B1_CONF + `RMB_ILIM_BIT];

  assign fldB2Volt  = regVals[8*B2_VOLT +: 5];
  assign fldB2Mode  = regVals[8*B2_MODE +: 4];
  assign fldB2Phase = regVals[8*B2_CONF + `RMB_PHASE_LSB +: 2];
  assign fldB2Freq  = regVals[8*B2_CONF + `RMB_FREQ_LSB +: 2];
  assign fldB2Ilim  = regVals[8*B2_CONF + `RMB_ILIM_BIT];

  assign fldB3Volt  = regVals[8*B3_VOLT +: 5];
  assign fldB3Mode  = regVals[8*B3_MODE +: 4];
  assign fldB3Phase = regVals[8*B3_CONF + `RMB_PHASE_LSB +: 2];
  assign fldB3Freq  = regVals[8*B3_CONF + `RMB_FREQ_LSB +: 2];
  assign fldB3Ilim  = regVals[8*B3_CONF + `RMB_ILIM_BIT];

  assign fldAonVolt = regVals[8*AON_CTL +: 3];

  // ---------------------------------------------------------------
  // Field outputs to the converters, registered
  // ---------------------------------------------------------------
  // Current limit bit: 0 selects the higher limit, 1 the lower one
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buckOneVoltageSel      <= 5'h00;
      buckOneModeSel         <= 4'h0;
      buckOnePhaseSel        <= 2'h0;
      buckOneFreqSel         <= 2'h0;
      buckOneCurrentLimitSel <= 1'b0;
    end else begin
      buckOneVoltageSel      <= fldB1Volt;
      buckOneModeSel         <= fldB1Mode;
      buckOnePhaseSel        <= fldB1Phase;
      buckOneFreqSel         <= fldB1Freq;
      buckOneCurrentLimitSel <= fldB1Ilim;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buckTwoVoltageSel      <= 5'h00;
      buckTwoModeSel         <= 4'h0;
      buckTwoPhaseSel        <= 2'h0;
      buckTwoFreqSel         <= 2'h0;
      buckTwoCurrentLimitSel <= 1'b0;
    end else begin
      buckTwoVoltageSel      <= fldB2Volt;
      buckTwoModeSel         <= fldB2Mode;
      buckTwoPhaseSel        <= fldB2Phase;
      buckTwoFreqSel         <= fldB2Freq;
      buckTwoCurrentLimitSel <= fldB2Ilim;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buckThreeVoltageSel      <= 5'h00;
      buckThreeModeSel         <= 4'h0;
      buckThreePhaseSel        <= 2'h0;
      buckThreeFreqSel         <= 2'h0;
      buckThreeCurrentLimitSel <= 1'b0;
    end else begin
      buckThreeVoltageSel      <= fldB3Volt;
      buckThreeModeSel         <= fldB3Mode;
      buckThreePhaseSel        <= fldB3Phase;
      buckThreeFreqSel         <= fldB3Freq;
      buckThreeCurrentLimitSel <= fldB3Ilim;
    end
  end

  // No code is reserved; the field is stored and passed as written
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alwaysOnSupplyVoltageSel <= 3'h0;
    end else begin
      alwaysOnSupplyVoltageSel <= fldAonVolt;
    end
  end
endmodule
`default_nettype wire

/* core/rmb_defs.vh */
// Register offsets, field layouts and the scratch reset value of the buck register bank
`ifndef RMB_DEFS_VH
`define RMB_DEFS_VH

// Register offsets within the functional page
`define RMB_OFS_SCRATCH_C  8'h1C
`define RMB_OFS_SCRATCH_D  8'h1D
`define RMB_OFS_B1_VOLT    8'h20
`define RMB_OFS_B1_MODE    8'h21
`define RMB_OFS_B1_CONF    8'h22
`define RMB_OFS_B2_VOLT    8'h23
`define RMB_OFS_B2_MODE    8'h24
`define RMB_OFS_B2_CONF    8'h25
`define RMB_OFS_B3_VOLT    8'h26
`define RMB_OFS_B3_MODE    8'h27
`define RMB_OFS_B3_CONF    8'h28
`define RMB_OFS_AON_CTL    8'h29

// Implemented-bit masks
`define RMB_MASK_SCRATCH   8'hFF
`define RMB_MASK_VOLT      8'h1F
`define RMB_MASK_MODE      8'h0F
`define RMB_MASK_CONF      8'h3D
`define RMB_MASK_AON       8'h07

// Field positions
`define RMB_VOLT_MSB       4
`define RMB_MODE_MSB       3
`define RMB_PHASE_MSB      5
`define RMB_PHASE_LSB      4
`define RMB_FREQ_MSB       3
`define RMB_FREQ_LSB       2
`define RMB_ILIM_BIT       0
`define RMB_AON_MSB        2

// Fixed reset value of the retained scratch cells
`define RMB_RST_SCRATCH    8'h00
// Value returned for unmapped addresses
`define RMB_RD_UNMAPPED    8'h00

`endif

/* core/rmb_scratch_cell.v */
// Retained scratch byte, cleared only by the coin-cell power-on reset
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defs.vh"
module rmb_scratch_cell (
  input  wire       core_clk,
  input  wire       coin_cell_power_on_reset_n,
  input  wire       wrEn,
  input  wire [7:0] wrData,
  output wire [7:0] value
);
  reg [7:0] data_ff;

  // Main reset is deliberately not wired here so contents survive it
  always @(posedge core_clk or negedge coin_cell_power_on_reset_n) begin
    if (!coin_cell_power_on_reset_n) begin
      data_ff <= `RMB_RST_SCRATCH;
    end else if (wrEn) begin
      data_ff <= wrData;
    end
  end

  assign value = data_ff;
endmodule
`default_nettype wire

/* core/rmb_masked_reg.v */
// Byte register with implemented-bit mask and start-up default load
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defs.vh"
module rmb_masked_reg #(
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire       loadDefault,
  input  wire [7:0] defaultValue,
  input  wire       wrEn,
  input  wire [7:0] wrData,
  output wire [7:0] value
);
  reg [7:0] data_ff;

  // Default comes from a port, so it is loaded by a clocked strobe after
  // reset release rather than inside the asynchronous reset branch
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ff <= 8'h00;
    end else if (loadDefault) begin
      data_ff <= defaultValue & MASK;
    end else if (wrEn) begin
      data_ff <= wrData & MASK;
    end
  end

  assign value = data_ff;
endmodule
`default_nettype wire

/* sim/rmb_buck_regs_monitor.sv */
// Port-level assertions for the buck register bank
`timescale 1ns/1ps
`default_nettype none
module rmb_buck_regs_monitor (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       loadDefaults,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] otpBuckOneVoltage,
  input wire logic [4:0] buckOneVoltageSel,
  input wire logic [3:0] buckOneModeSel,
  input wire logic [1:0] buckOnePhaseSel,
  input wire logic [1:0] buckOneFreqSel,
  input wire logic       buckOneCurrentLimitSel,
  input wire logic       buckThreeCurrentLimitSel,
  input wire logic [2:0] alwaysOnSupplyVoltageSel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // A write colliding with a default load loses, so it is left out
  wire wrGo = regWrite && !loadDefaults;
  wire gap = regAddr < 8'h1C || regAddr > 8'h29 || regAddr[7:1] == 7'h0F;
  chk_volt_write: assert property (wrGo && regAddr == 8'h20
    |-> ##2 buckOneVoltageSel == 5'($past(regWrData, 2)))
    else $error("voltage field mismatch");
  chk_mode_write: assert property (wrGo && regAddr == 8'h21
    |-> ##2 buckOneModeSel == 4'($past(regWrData, 2)))
    else $error("mode field mismatch");
  chk_conf_fields: assert property (wrGo && regAddr == 8'h22
    |-> ##2 {buckOnePhaseSel, buckOneFreqSel, 1'b0, buckOneCurrentLimitSel}
    == 6'($past(regWrData, 2) & 8'h3D)) else $error("config fields wrong");
  chk_limit_three: assert property (wrGo && regAddr == 8'h28
    |-> ##2 buckThreeCurrentLimitSel == 1'($past(regWrData, 2)))
    else $error("third limit bit wrong");
  chk_aon_write: assert property (wrGo && regAddr == 8'h29
    |-> ##2 alwaysOnSupplyVoltageSel == 3'($past(regWrData, 2)))
    else $error("always-on field wrong");
  chk_default_load: assert property (loadDefaults
    |-> ##2 buckOneVoltageSel == 5'($past(otpBuckOneVoltage, 2)))
    else $error("default not loaded");
  chk_gap_read: assert property (regRead && gap
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  chk_pad_bits: assert property (regRead && regAddr == 8'h20
    |=> regRdData[7:5] == 3'b000) else $error("unused bits not zero");
endmodule
bind rmb_buck_regs rmb_buck_regs_monitor i_mon (.core_clk, .reset_n,
  .loadDefaults, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
  .otpBuckOneVoltage, .buckOneVoltageSel, .buckOneModeSel, .buckOnePhaseSel,
  .buckOneFreqSel, .buckOneCurrentLimitSel, .buckThreeCurrentLimitSel,
  .alwaysOnSupplyVoltageSel);
`default_nettype wire

/* sim/rmb_host_model.sv */
// Host-side register access model
`timescale 1ns/1ps
`default_nettype none
module rmb_host_model (
  input  wire logic       core_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData
);
  initial {regWrite, regRead, regAddr, regWrData} = 18'h00000;
  // One 8-bit request per cycle, any order, no locking
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    {regWrite, regRead, regAddr, regWrData} = {w, r, a, d};
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

/* sim/rmb_buck_regs_tb.sv */
// Self-checking bench for the buck register bank
`timescale 1ns/1ps
`default_nettype none
module rmb_buck_regs_tb;
  logic core_clk, reset_n, coin_cell_power_on_reset_n, loadDefaults;
  logic regWrite, regRead, buckOneCurrentLimitSel, buckTwoCurrentLimitSel;
  logic [7:0] regAddr, regWrData, regRdData, otpBuckOneVoltage;
  logic [7:0] otpBuckOneConfig, otpBuckTwoConfig, otpBuckThreeConfig;
  logic [7:0] seqBuckOneMode, seqBuckTwoVoltage, seqBuckTwoMode;
  logic [7:0] seqBuckThreeVoltage, seqBuckThreeMode, seqAlwaysOnControl;
  logic [4:0] buckOneVoltageSel, buckTwoVoltageSel, buckThreeVoltageSel;
  logic [3:0] buckOneModeSel, buckTwoModeSel, buckThreeModeSel;
  logic [1:0] buckOnePhaseSel, buckTwoPhaseSel, buckThreePhaseSel;
  logic [1:0] buckOneFreqSel, buckTwoFreqSel, buckThreeFreqSel;
  logic       buckThreeCurrentLimitSel;
  logic [2:0] alwaysOnSupplyVoltageSel;
  logic [7:0] dflt[10];
  int ex[256];
  int ofs[10] = '{8'h20, 8'h22, 8'h25, 8'h28, 8'h21, 8'h23, 8'h24, 8'h26,
                  8'h27, 8'h29};
  int failures = 0, checkCount = 0, d;
  rmb_buck_regs i_dut (.core_clk, .reset_n, .coin_cell_power_on_reset_n,
    .loadDefaults, .otpBuckOneVoltage, .otpBuckOneConfig, .otpBuckTwoConfig,
    .otpBuckThreeConfig, .seqBuckOneMode, .seqBuckTwoVoltage, .seqBuckTwoMode,
    .seqBuckThreeVoltage, .seqBuckThreeMode, .seqAlwaysOnControl, .regWrite,
    .regRead, .regAddr, .regWrData, .regRdData, .buckOneVoltageSel,
    .buckTwoVoltageSel, .buckThreeVoltageSel, .buckOneModeSel, .buckTwoModeSel,
    .buckThreeModeSel, .buckOnePhaseSel, .buckTwoPhaseSel, .buckThreePhaseSel,
    .buckOneFreqSel, .buckTwoFreqSel, .buckThreeFreqSel,
    .buckOneCurrentLimitSel, .buckTwoCurrentLimitSel,
    .buckThreeCurrentLimitSel, .alwaysOnSupplyVoltageSel);
  rmb_host_model i_host (.core_clk, .regWrite, .regRead, .regAddr, .regWrData);
  function automatic int msk(int a);
    case (a)
      8'h1C, 8'h1D:        return 8'hFF;
      8'h20, 8'h23, 8'h26: return 8'h1F;
      8'h21, 8'h24, 8'h27: return 8'h0F;
      8'h22, 8'h25, 8'h28: return 8'h3D;
      8'h29:               return 8'h07;
      default:             return 8'h00;
    endcase
  endfunction
  function automatic logic [4:0] cf(int c);
    return {c[5:2], c[0]};
  endfunction
  task automatic cmp(logic [44:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdAll();
    for (int a = 0; a < 256; a++) begin
      i_host.bus(1'b0, 1'b1, 8'(a), 8'($urandom));
      cmp(45'(regRdData), 45'(ex[a]));
    end
  endtask
  // Two idle cycles cover the field outputs' lag behind the registers
  task automatic fields(string s);
    i_host.bus(1'b0, 1'b0, 8'($urandom), 8'($urandom));
    i_host.bus(1'b0, 1'b0, 8'($urandom), 8'($urandom));
    cmp({buckOneVoltageSel, buckTwoVoltageSel, buckThreeVoltageSel,
      buckOneModeSel, buckTwoModeSel, buckThreeModeSel, buckOnePhaseSel,
      buckOneFreqSel, buckOneCurrentLimitSel, buckTwoPhaseSel, buckTwoFreqSel,
      buckTwoCurrentLimitSel, buckThreePhaseSel, buckThreeFreqSel,
      buckThreeCurrentLimitSel, alwaysOnSupplyVoltageSel},
      {5'(ex[8'h20]), 5'(ex[8'h23]), 5'(ex[8'h26]), 4'(ex[8'h21]),
      4'(ex[8'h24]), 4'(ex[8'h27]), cf(ex[8'h22]), cf(ex[8'h25]),
      cf(ex[8'h28]), 3'(ex[8'h29])});
    $display("test %s finished", s);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #60000;
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(32'h69FA));
    {reset_n, coin_cell_power_on_reset_n, loadDefaults} = 3'h0;
    {otpBuckOneVoltage, otpBuckOneConfig, otpBuckTwoConfig, otpBuckThreeConfig,
      seqBuckOneMode, seqBuckTwoVoltage, seqBuckTwoMode, seqBuckThreeVoltage,
      seqBuckThreeMode, seqAlwaysOnControl} =
      80'({$urandom, $urandom, $urandom});
    repeat (6) @(negedge core_clk);
    {reset_n, coin_cell_power_on_reset_n} = 2'h3;
    rdAll();
    // Default load wins over a write in the same cycle
    loadDefaults = 1'b1;
    i_host.bus(1'b1, 1'b0, 8'h20, ~otpBuckOneVoltage);
    loadDefaults = 1'b0;
    dflt = '{otpBuckOneVoltage, otpBuckOneConfig, otpBuckTwoConfig,
      otpBuckThreeConfig, seqBuckOneMode, seqBuckTwoVoltage, seqBuckTwoMode,
      seqBuckThreeVoltage, seqBuckThreeMode, seqAlwaysOnControl};
    foreach (ofs[i]) ex[ofs[i]] = dflt[i] & msk(ofs[i]);
    rdAll();
    fields("defaults");
    for (int p = 0; p < 2; p++)
      for (int a = 0; a < 256; a++) begin
        d = {$urandom, p[0]};
        i_host.bus(1'b1, 1'b0, 8'(a), 8'(d));
        ex[a] = d & msk(a);
        i_host.bus(1'b0, 1'b1, 8'(a), 8'($urandom));
        cmp(45'(regRdData), 45'(ex[a]));
      end
    fields("sweep");
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    foreach (ofs[i]) ex[ofs[i]] = 0;
    rdAll();
    fields("main reset");
    coin_cell_power_on_reset_n = 1'b0;
    @(negedge core_clk);
    coin_cell_power_on_reset_n = 1'b1;
    ex[8'h1C] = 0;
    ex[8'h1D] = 0;
    rdAll();
    fields("coin reset");
    conclude();
  end
endmodule
`default_nettype wire
